/* File: hdl/adcrb_cfg.svh */
// register offsets, field positions, reset values and bus responses
`ifndef ADCRB_CFG_SVH
`define ADCRB_CFG_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ADCRB_OFF_RES_LO 8'h00
`define ADCRB_OFF_RES_HI 8'h04
`define ADCRB_OFF_LB_LO 8'h08
`define ADCRB_OFF_LB_HI 8'h0C
`define ADCRB_OFF_HB_LO 8'h10
`define ADCRB_OFF_HB_HI 8'h14
`define ADCRB_OFF_CTL0 8'h18
`define ADCRB_OFF_CTL1 8'h1C
`define ADCRB_OFF_CTL2 8'h20
`define ADCRB_OFF_DLY 8'h24
`define ADCRB_OFF_PIN 8'h28
`define ADCRB_OFF_STAT 8'h2C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ADCRB_C0_START 7
`define ADCRB_C0_BUSY 6
`define ADCRB_C0_EN 5
`define ADCRB_C0_ALIGN 4
`define ADCRB_C1_WMASK 8'hE7
`define ADCRB_C2_SRC 7
`define ADCRB_C2_DLY 6
`define ADCRB_C2_PWIS 5
`define ADCRB_C2_WMASK 8'hFB
`define ADCRB_C0_WMASK 8'hBF

// ----------------------------------------------------------------------
// reset values and responses
// ----------------------------------------------------------------------
`define ADCRB_RST_BYTE 8'h00
`define ADCRB_RST_PIN 8'hFF
`define ADCRB_RESP_OKAY 2'b00
`define ADCRB_RESP_SLVERR 2'b10

`endif

/* File: hdl/adcrb_pkg.sv */
// types shared by the converter register block
package adcrb_pkg;
  typedef logic [11:0] adcrb_sample_t;
  typedef logic [7:0] adcrb_byte_t;
  typedef enum logic [1:0] {
    ADCRB_IDLE = 2'b00,
    ADCRB_WAIT = 2'b01,
    ADCRB_CONV = 2'b11
  } adcrb_state_e;
endpackage : adcrb_pkg

/* File: hdl/adcrb_core_if.sv */
// link between the register block and its clock divider
`timescale 1ns/100ps
`default_nettype none
interface adcrb_core_if;
  logic [2:0] div_sel;
  logic div_tick;
  modport ctrl (output div_sel, input div_tick);
  modport div (input div_sel, output div_tick);
endinterface : adcrb_core_if
`default_nettype wire

/* File: hdl/adcrb_clkdiv.sv */
// power-of-two conversion clock divider
`timescale 1ns/100ps
`default_nettype none
module adcrb_clkdiv (
  input wire logic mclk,
  input wire logic arst_n,
  adcrb_core_if.div cif
);
  logic [6:0] cnt_q;
  logic [6:0] mask;

  // code n divides by 2**n: tick when low n bits all ones
  assign mask = ~(7'h7F << cif.div_sel);
  assign cif.div_tick = ((cnt_q & mask) == mask);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end
endmodule : adcrb_clkdiv
`default_nettype wire

/* File: hdl/adcrb_top.sv */
// converter result, boundary and control registers on an axi4-lite slave
// Contract
// - 12-bit result shown as high and low bytes, both read-only.
// - align 0: high byte bits 11..4, low byte upper nibble bits 3..0.
// - align 1: high byte low nibble bits 11..8, low byte bits 7..0.
// - unoccupied result bit positions always read zero.
// - converter disabled keeps the result pair unchanged.
// - high and low bound pairs compared with result raise an interrupt.
// - bound pairs use the same alignment layout, unused bits zero.
// - converter disabled keeps the bound registers unchanged.
// - one converter; source and channel fields pick the single input.
// - start delay register holds count used only for delayed start.
// - 8-bit control registers for channel, format, clock, start, status.
// - separate pin-share settings pick which pins are analog inputs.
// - start bit high then low starts; busy set, cleared when done.
// - code 00 between, 01 at/below low, 10 at/above high, 11 either.
// - delayed start counts programmed clocks after pwm flag rising edge.
// - clock select divides system clock by 2**code, up to 128.
`timescale 1ns/100ps
`include "adcrb_cfg.svh"
`default_nettype none
module adcrb_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire adcrb_pkg::adcrb_sample_t conv_data,
  input wire logic conv_done,
  input wire logic pwm_period_flag,
  input wire logic [1:0] pwm_duty_flag,
  output logic conv_start,
  output logic conv_clk_tick,
  output logic conv_power_en,
  output adcrb_pkg::adcrb_byte_t ana_sel_ctl,
  output logic [2:0] ana_src_sel,
  output logic [7:0] pin_analog_en,
  output logic cmp_irq
);
  import adcrb_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  adcrb_sample_t res_q, lb_q, hb_q;
  adcrb_byte_t c0_q, c1_q, c2_q, dly_q, pin_q;
  logic busy_q, cmp_q, startarm_q, pwm_prev_q;
  adcrb_state_e st_q;
  logic [7:0] dcnt_q;
  logic aw_q, w_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;

  adcrb_core_if cif ();
  adcrb_clkdiv adcrb_clkdiv_inst (
    .mclk(mclk),
    .arst_n(arst_n),
    .cif(cif)
  );
  assign cif.div_sel = c1_q[2:0];
  assign conv_clk_tick = cif.div_tick;

  // ----------------------------------------------------------------------
  // alignment helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] fmt(input logic [11:0] v, input logic r);
    fmt = r ? {4'h0, v} : {v, 4'h0};
  endfunction : fmt

  function automatic logic [11:0] upd(input logic [11:0] v, input logic r,
                                      input logic hi, input logic [7:0] b);
    logic [15:0] f;
    f = fmt(v, r);
    if (hi) begin
      f[15:8] = b;
    end else begin
      f[7:0] = b;
    end
    upd = r ? f[11:0] : f[15:4];
  endfunction : upd

  logic align;
  logic enable;
  logic [15:0] res_f, lb_f, hb_f;
  assign align = c0_q[`ADCRB_C0_ALIGN];
  assign enable = c0_q[`ADCRB_C0_EN];
  assign res_f = fmt(res_q, align);
  assign lb_f = fmt(lb_q, align);
  assign hb_f = fmt(hb_q, align);

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  logic wr_go;
  logic wr_lo;
  logic wr_map;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign wr_lo = ws_q[0];
  assign wr_map = (awa_q[1:0] == 2'b00) && (awa_q <= `ADCRB_OFF_STAT);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCRB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `ADCRB_RESP_OKAY : `ADCRB_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wsel_c0, wsel_c1, wsel_c2, wsel_dly, wsel_pin;
  logic wsel_lbl, wsel_lbh, wsel_hbl, wsel_hbh;
  assign wsel_c0 = wr_go && wr_lo && (awa_q == `ADCRB_OFF_CTL0);
  assign wsel_c1 = wr_go && wr_lo && (awa_q == `ADCRB_OFF_CTL1);
  assign wsel_c2 = wr_go && wr_lo && (awa_q == `ADCRB_OFF_CTL2);
  assign wsel_dly = wr_go && wr_lo && (awa_q == `ADCRB_OFF_DLY);
  assign wsel_pin = wr_go && wr_lo && (awa_q == `ADCRB_OFF_PIN);
  assign wsel_lbl = wr_go && wr_lo && (awa_q == `ADCRB_OFF_LB_LO);
  assign wsel_lbh = wr_go && wr_lo && (awa_q == `ADCRB_OFF_LB_HI);
  assign wsel_hbl = wr_go && wr_lo && (awa_q == `ADCRB_OFF_HB_LO);
  assign wsel_hbh = wr_go && wr_lo && (awa_q == `ADCRB_OFF_HB_HI);

  // ----------------------------------------------------------------------
  // control and bound registers
  // ----------------------------------------------------------------------
  // result offsets have no write select at all
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      c0_q <= `ADCRB_RST_BYTE;
      c1_q <= `ADCRB_RST_BYTE;
      c2_q <= `ADCRB_RST_BYTE;
      dly_q <= `ADCRB_RST_BYTE;
      pin_q <= `ADCRB_RST_PIN;
      lb_q <= 12'h000;
      hb_q <= 12'h000;
    end else begin
      if (wsel_c0) c0_q <= wd_q[7:0] & `ADCRB_C0_WMASK;
      if (wsel_c1) c1_q <= wd_q[7:0] & `ADCRB_C1_WMASK;
      if (wsel_c2) c2_q <= wd_q[7:0] & `ADCRB_C2_WMASK;
      if (wsel_dly) dly_q <= wd_q[7:0];
      if (wsel_pin) pin_q <= wd_q[7:0];
      // bounds frozen while disabled
      if (enable && (wsel_lbl || wsel_lbh)) begin
        lb_q <= upd(lb_q, align, wsel_lbh, wd_q[7:0]);
      end
      if (enable && (wsel_hbl || wsel_hbh)) begin
        hb_q <= upd(hb_q, align, wsel_hbh, wd_q[7:0]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // start control and delay
  // ----------------------------------------------------------------------
  // start is armed by a 1 then fired by the following 0 write
  logic sw_fire;
  logic pwm_sel;
  logic pwm_rise;
  logic delay_fire;
  assign sw_fire = wsel_c0 && startarm_q &&
                   !wd_q[`ADCRB_C0_START];
  assign pwm_sel = c2_q[`ADCRB_C2_PWIS] ?
                   pwm_duty_flag[c2_q[0]] : pwm_period_flag;
  assign pwm_rise = pwm_sel && !pwm_prev_q;
  // a disable during the wait must not leak a start to the core
  assign delay_fire = (st_q == ADCRB_WAIT) && enable && (dcnt_q <= 8'h01);
  assign conv_start = (st_q == ADCRB_IDLE) ? (enable &&
                      !c2_q[`ADCRB_C2_SRC] && sw_fire) : delay_fire;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      startarm_q <= 1'b0;
      pwm_prev_q <= 1'b0;
    end else begin
      pwm_prev_q <= pwm_sel;
      if (wsel_c0) startarm_q <= wd_q[`ADCRB_C0_START];
    end
  end

  // idle -> wait (delay) -> conv -> idle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ADCRB_IDLE;
      dcnt_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      unique case (st_q)
        ADCRB_IDLE: begin
          if (conv_start) begin
            st_q <= ADCRB_CONV;
            busy_q <= 1'b1;
          end else if (enable && c2_q[`ADCRB_C2_SRC] &&
                       c2_q[`ADCRB_C2_DLY] && pwm_rise) begin
            st_q <= ADCRB_WAIT;
            dcnt_q <= dly_q;
          end
        end
        ADCRB_WAIT: begin
          dcnt_q <= dcnt_q - 8'h01;
          if (!enable) begin
            st_q <= ADCRB_IDLE;
          end else if (delay_fire) begin
            st_q <= ADCRB_CONV;
            busy_q <= 1'b1;
          end
        end
        ADCRB_CONV: begin
          if (conv_done || !enable) begin
            st_q <= ADCRB_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: st_q <= ADCRB_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // result capture and compare
  // ----------------------------------------------------------------------
  logic at_lo, at_hi, hit;
  assign at_lo = (conv_data <= lb_q);
  assign at_hi = (conv_data >= hb_q);
  always_comb begin
    unique case (c2_q[4:3])
      2'b00: hit = !at_lo && !at_hi;
      2'b01: hit = at_lo;
      2'b10: hit = at_hi;
      2'b11: hit = at_lo || at_hi;
    endcase
  end

  logic done_ok;
  assign done_ok = (st_q == ADCRB_CONV) && conv_done && enable;

  // cmp flag sticky; software write of 1 to bit 0 clears, set wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      res_q <= 12'h000;
      cmp_q <= 1'b0;
    end else begin
      if (done_ok) res_q <= conv_data;
      if (done_ok && hit) begin
        cmp_q <= 1'b1;
      end else if (wr_go && wr_lo && wd_q[0] &&
                   awa_q == `ADCRB_OFF_STAT) begin
        cmp_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read channel and outputs
  // ----------------------------------------------------------------------
  logic [7:0] rd_byte;
  logic rd_map;
  always_comb begin
    rd_map = 1'b1;
    unique case (s_axi_araddr)
      `ADCRB_OFF_RES_LO: rd_byte = res_f[7:0];
      `ADCRB_OFF_RES_HI: rd_byte = res_f[15:8];
      `ADCRB_OFF_LB_LO: rd_byte = lb_f[7:0];
      `ADCRB_OFF_LB_HI: rd_byte = lb_f[15:8];
      `ADCRB_OFF_HB_LO: rd_byte = hb_f[7:0];
      `ADCRB_OFF_HB_HI: rd_byte = hb_f[15:8];
      `ADCRB_OFF_CTL0: rd_byte = {c0_q[7], busy_q, c0_q[5:0]};
      `ADCRB_OFF_CTL1: rd_byte = c1_q;
      `ADCRB_OFF_CTL2: rd_byte = c2_q;
      `ADCRB_OFF_DLY: rd_byte = dly_q;
      `ADCRB_OFF_PIN: rd_byte = pin_q;
      `ADCRB_OFF_STAT: rd_byte = {7'h00, cmp_q};
      default: begin
        rd_byte = 8'h00;
        rd_map = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ADCRB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_map ? `ADCRB_RESP_OKAY : `ADCRB_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // internal source forces channel off, so one signal reaches the core
  assign conv_power_en = enable;
  assign ana_src_sel = c1_q[7:5];
  assign ana_sel_ctl = (c1_q[7:5] == 3'b001 || c1_q[7:6] == 2'b01) ?
                       8'h00 : {4'h1, c0_q[3:0]};
  assign pin_analog_en = pin_q;
  assign cmp_irq = cmp_q;
endmodule : adcrb_top
`default_nettype wire

/* File: bench/adcrb_core_model.sv */
// behavioural analog core answering conversion starts
`timescale 1ns/100ps
`default_nettype none
module adcrb_core_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic conv_start,
  input wire logic [7:0] lat,
  input wire logic [11:0] sample,
  output logic [11:0] conv_data,
  output logic conv_done
);
  logic [7:0] cnt_q;
  logic tg_q;
  // data valid only with done; a moving pattern otherwise
  assign conv_done = (cnt_q == 8'h01);
  assign conv_data = conv_done ? sample : (~sample ^ {6{tg_q, ~tg_q}});
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 8'h00;
      tg_q <= 1'b0;
    end else begin
      tg_q <= ~tg_q;
      if (conv_start) cnt_q <= lat;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : adcrb_core_model
`default_nettype wire

/* File: bench/adcrb_top_props.sv */
// bus and converter-side checks on the register block ports
`timescale 1ns/100ps
`default_nettype none
module adcrb_props (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_start,
  input wire logic conv_power_en,
  input wire adcrb_pkg::adcrb_byte_t ana_sel_ctl,
  input wire logic [2:0] ana_src_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic int_src;
  assign int_src = (ana_src_sel inside {3'd1, 3'd2, 3'd3});
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_ans; s_wr_take |-> ##2 s_axi_bvalid; endproperty
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_rd_ans; s_rd_take |=> s_axi_rvalid; endproperty
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_rd_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  property p_start_en; conv_start |-> conv_power_en; endproperty
  property p_int_src; int_src |-> ana_sel_ctl == 8'h00; endproperty
  property p_ext_src; !int_src |-> ana_sel_ctl[7:4] == 4'h1; endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write not answered");
  a_b_once: assert property (p_b_once)
    else $error("write response repeated");
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  a_r_once: assert property (p_r_once)
    else $error("read response repeated");
  a_rd_block: assert property (p_rd_block)
    else $error("read accepted while answering");
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  a_start_en: assert property (p_start_en)
    else $error("start while disabled");
  a_int_src: assert property (p_int_src)
    else $error("external path on with internal source");
  a_ext_src: assert property (p_ext_src)
    else $error("external path off with external source");
endmodule : adcrb_props
bind adcrb_top adcrb_props adcrb_props_inst (.mclk(mclk), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .conv_start(conv_start), .conv_power_en(conv_power_en),
  .ana_sel_ctl(ana_sel_ctl), .ana_src_sel(ana_src_sel));
`default_nettype wire

/* File: bench/tb_adc_result_boundary_regs.sv */
// self-checking bench for the converter register block
`timescale 1ns/100ps
`include "adcrb_cfg.svh"
`default_nettype none
module tb_adc_result_boundary_regs;
  import adcrb_pkg::*;
  logic mclk, arst_n, awvalid, wvalid, bready, arvalid, rready, pflag;
  logic awready, wready, bvalid, arready, rvalid, done, start, tick, pwr;
  logic irq;
  logic [7:0] awaddr, araddr, sel, pin, lat;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp, dflag;
  logic [11:0] smp, cdata;
  logic [2:0] src;
  int errors, checks, n, d3, d9;
  adcrb_top adcrb_top_inst (.mclk(mclk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_data(cdata),
    .conv_done(done), .pwm_period_flag(pflag), .pwm_duty_flag(dflag),
    .conv_start(start), .conv_clk_tick(tick), .conv_power_en(pwr),
    .ana_sel_ctl(sel), .ana_src_sel(src), .pin_analog_en(pin),
    .cmp_irq(irq));
  adcrb_core_model adcrb_core_model_inst (.mclk(mclk), .arst_n(arst_n),
    .conv_start(start), .lat(lat), .sample(smp), .conv_data(cdata),
    .conv_done(done));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // bus, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // ready is sampled mid-cycle, so release lands right on the taking edge
  task automatic bus(input logic w, input logic [7:0] a, d);
    logic ta, tw, tr;
    int k;
    @(posedge mclk);
    awaddr <= a;
    araddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    k = 0;
    do begin
      @(negedge mclk);
      ta = w ? awready : arready;
      tw = wready;
      tr = w ? bvalid : rvalid;
      rd = rdata;
      rsp = w ? bresp : rresp;
      k++;
      @(posedge mclk);
      if (w && ta) awvalid <= 1'b0;
      if (w && tw) wvalid <= 1'b0;
      if (!w && ta) arvalid <= 1'b0;
    end while (!tr && k < 40);
    bready <= 1'b0;
    rready <= 1'b0;
    if (!tr) begin
      chk("bus_answer", 1, 0);
      end_sim();
    end
  endtask : bus
  task automatic rdc(input logic [7:0] a, e);
    bus(0, a, 8'h00);
    chk($sformatf("reg_%h", a), {24'h00_0000, e}, rd);
  endtask : rdc
  task automatic idle;
    int k;
    k = 0;
    do begin
      bus(0, `ADCRB_OFF_CTL0, 8'h00);
      k++;
    end while (rd[6] !== 1'b0 && k < 40);
    chk("busy_end", 0, rd[6]);
  endtask : idle
  task automatic conv(input logic [11:0] s, input logic [7:0] c0);
    smp <= s;
    bus(1, `ADCRB_OFF_CTL0, c0 | 8'h80);
    bus(1, `ADCRB_OFF_CTL0, c0);
    bus(0, `ADCRB_OFF_CTL0, 8'h00);
    chk("busy", 1, rd[6]);
    idle();
  endtask : conv
  task automatic dly(input logic [2:0] f, output int c);
    @(posedge mclk);
    {dflag, pflag} <= f;
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (!start && c < 60);
    @(posedge mclk);
    {dflag, pflag} <= 3'b000;
    if (c < 60) idle();
  endtask : dly
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc(`ADCRB_OFF_CTL0, 8'h00);
    rdc(`ADCRB_OFF_RES_HI, 8'h00);
    rdc(`ADCRB_OFF_DLY, 8'h00);
    rdc(`ADCRB_OFF_PIN, 8'hff);
    bus(0, 8'h30, 8'h00);
    chk("unmapped_resp", `ADCRB_RESP_SLVERR, rsp);
    $display("test reset done");
  endtask : t_reset
  task automatic t_bounds;
    bus(1, `ADCRB_OFF_CTL0, 8'h20);
    bus(1, `ADCRB_OFF_LB_HI, 8'hab);
    bus(1, `ADCRB_OFF_LB_LO, 8'hcf);
    rdc(`ADCRB_OFF_LB_LO, 8'hc0);
    bus(1, `ADCRB_OFF_CTL0, 8'h30);
    rdc(`ADCRB_OFF_LB_HI, 8'h0a);
    rdc(`ADCRB_OFF_LB_LO, 8'hbc);
    bus(1, `ADCRB_OFF_LB_HI, 8'h01);
    bus(1, `ADCRB_OFF_LB_LO, 8'h00);
    bus(1, `ADCRB_OFF_HB_HI, 8'h08);
    bus(1, `ADCRB_OFF_HB_LO, 8'h00);
    bus(1, `ADCRB_OFF_CTL0, 8'h10);
    bus(1, `ADCRB_OFF_HB_LO, 8'h55);
    rdc(`ADCRB_OFF_HB_LO, 8'h00);
    $display("test bounds done");
  endtask : t_bounds
  task automatic t_result;
    lat <= 8'd30;
    conv(12'ha53, 8'h20);
    rdc(`ADCRB_OFF_RES_HI, 8'ha5);
    rdc(`ADCRB_OFF_RES_LO, 8'h30);
    bus(1, `ADCRB_OFF_RES_HI, 8'hff);
    rdc(`ADCRB_OFF_RES_HI, 8'ha5);
    bus(1, `ADCRB_OFF_CTL0, 8'h30);
    rdc(`ADCRB_OFF_RES_HI, 8'h0a);
    rdc(`ADCRB_OFF_RES_LO, 8'h53);
    // start, then disable before the core answers: result must hold
    smp <= 12'hfff;
    bus(1, `ADCRB_OFF_CTL0, 8'hb0);
    bus(1, `ADCRB_OFF_CTL0, 8'h30);
    bus(1, `ADCRB_OFF_CTL0, 8'h10);
    chk("power_off", 0, pwr);
    repeat (40) @(posedge mclk);
    rdc(`ADCRB_OFF_RES_LO, 8'h53);
    $display("test result done");
  endtask : t_result
  task automatic t_compare;
    logic [11:0] s;
    logic e;
    lat <= 8'd6;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 3; k++) begin
        s = (k == 0) ? 12'h400 : (k == 1) ? 12'h100 : 12'h800;
        e = (m == 0) ? (s > 12'h100 && s < 12'h800) :
            (m == 1) ? (s <= 12'h100) : (m == 2) ? (s >= 12'h800) :
            (s <= 12'h100 || s >= 12'h800);
        bus(1, `ADCRB_OFF_CTL2, 8'(m << 3));
        conv(s, k[0] ? 8'h20 : 8'h30);
        chk("cmp_irq", e, irq);
        rdc(`ADCRB_OFF_STAT, {7'h00, e});
        bus(1, `ADCRB_OFF_STAT, 8'h01);
      end
    end
    chk("cmp_irq_clear", 0, irq);
    $display("test compare done");
  endtask : t_compare
  task automatic t_src;
    bus(1, `ADCRB_OFF_CTL0, 8'h23);
    chk("power_on", 1, pwr);
    bus(1, `ADCRB_OFF_CTL1, 8'hff);
    rdc(`ADCRB_OFF_CTL1, 8'he7);
    bus(1, `ADCRB_OFF_CTL1, 8'h20);
    chk("src", 3'd1, src);
    chk("sel_int", 8'h00, sel);
    bus(1, `ADCRB_OFF_CTL1, 8'h00);
    chk("sel_ext", 8'h13, sel);
    bus(1, `ADCRB_OFF_PIN, 8'h5a);
    chk("pin", 8'h5a, pin);
    for (int c = 1; c < 8; c++) begin
      bus(1, `ADCRB_OFF_CTL1, 8'(c));
      n = 0;
      while (!tick && n < 300) begin
        @(negedge mclk);
        n++;
      end
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (!tick && n < 300);
      chk("tick_gap", 1 << c, n);
    end
    bus(1, `ADCRB_OFF_CTL1, 8'h00);
    @(negedge mclk);
    chk("tick_undivided", 1, tick);
    $display("test source done");
  endtask : t_src
  task automatic t_delay;
    bus(1, `ADCRB_OFF_CTL0, 8'h30);
    bus(1, `ADCRB_OFF_CTL2, 8'hc0);
    bus(1, `ADCRB_OFF_DLY, 8'd3);
    dly(3'b001, d3);
    bus(1, `ADCRB_OFF_DLY, 8'd9);
    dly(3'b001, d9);
    chk("delay_step", 6, d9 - d3);
    bus(1, `ADCRB_OFF_CTL2, 8'he1);
    dly(3'b100, d9);
    chk("duty_delay", d9 - 6, d3);
    bus(1, `ADCRB_OFF_CTL2, 8'h80);
    dly(3'b001, n);
    chk("no_trigger", 60, n);
    $display("test delay done");
  endtask : t_delay
  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready, pflag} = 7'h00;
    {awaddr, araddr, wdata, dflag, smp, lat} = 0;
    errors = 0;
    checks = 0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_bounds();
    t_result();
    t_compare();
    t_src();
    t_delay();
    end_sim();
  end
  initial begin
    repeat (30000) @(posedge mclk);
    errors++;
    end_sim();
  end
endmodule : tb_adc_result_boundary_regs
`default_nettype wire
